// >>> sequencer_command_decoder.sv
// Executes the conditional commands of one sequencer task: fetches
// command words from a streamed list and acts on them.
// Assumes the fetch DMA presents words in list order on word_*.
`timescale 1ns/1ps
module sequencer_command_decoder #(
  parameter int EVENT_W = 26
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   srst,
  // Task control
  input  wire logic                   run_start,
  input  wire logic                   pc_load,
  input  wire logic [31:0]            pc_load_value,
  input  wire logic                   int_clear,
  input  wire logic                   late_clear,
  // Command word stream
  input  wire logic                   word_valid,
  input  wire logic [31:0]            word_data,
  output logic                        word_ready_r,
  // Event sources
  input  wire logic [EVENT_W-1:0]     event_src,
  // Task state
  output logic                        task_run_enable_r,
  output logic [31:0]                 task_program_counter_r,
  output logic                        task_interrupt_flag_r,
  output logic                        late_flag_r,
  output logic [EVENT_W-1:0]          event_copy_r,
  // Upload request
  output logic                        upload_strobe_r,
  output logic [10:0]                 upload_sections_r
);

  initial begin
    if (EVENT_W != seq_cmd_pkg::EVENT_W) $error("EVENT_W must match command field");
  end

  // ----------------------------------------------------------------
  // Condition evaluation
  // ----------------------------------------------------------------
  function automatic logic cond_eval(input logic [31:0] w, input logic [EVENT_W-1:0] ev);
    logic [EVENT_W-1:0] sel;
    logic               comb;
    sel  = w[seq_cmd_pkg::EVENT_HI:0];
    comb = w[seq_cmd_pkg::COMBINE_BIT] ? |(sel & ev) : &(~sel | ev);
    return w[seq_cmd_pkg::INVERT_BIT] ? ~comb : comb;
  endfunction

  // No event addressed forces the command
  function automatic logic cond_forced(input logic [31:0] w, input logic [EVENT_W-1:0] ev);
    if (w[seq_cmd_pkg::EVENT_HI:0] == '0) begin
      return 1'b1;
    end
    return cond_eval(w, ev);
  endfunction

  // ----------------------------------------------------------------
  // Event copies
  // ----------------------------------------------------------------
  logic [EVENT_W-1:0] sig_set;
  logic [EVENT_W-1:0] sig_clr;
  logic [EVENT_W-1:0] events;

  event_copy_bank #(
    .N (EVENT_W)
  ) u_events (
    .clk       (clk),
    .srst      (srst),
    .src_level (event_src),
    .set_mask  (sig_set),
    .clr_mask  (sig_clr),
    .events_r  (events)
  );

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_FETCH   = 2'b01,
    ST_OPERAND = 2'b11,
    ST_WAIT    = 2'b10
  } state_t;

  state_t               state_r;
  state_t               state_nxt;
  logic [31:0]          held_r;
  logic                 jump_go_r;
  logic                 take;
  seq_cmd_pkg::opcode_t opc;
  logic                 cond_now;
  logic                 cond_stop;
  logic                 cond_held;

  assign take      = word_valid && word_ready_r;
  assign opc       = seq_cmd_pkg::opcode_t'(
                       word_data[seq_cmd_pkg::OPC_HI:seq_cmd_pkg::OPC_LO]);
  assign cond_now  = cond_eval(word_data, events);
  assign cond_stop = cond_forced(word_data, events);
  assign cond_held = cond_eval(held_r, events);
  assign sig_set   = (state_r == ST_FETCH && take && opc == seq_cmd_pkg::OP_SET_SIGNAL)
                     ? word_data[seq_cmd_pkg::EVENT_HI:0] : '0;
  assign sig_clr   = (state_r == ST_FETCH && take && opc == seq_cmd_pkg::OP_SIGNAL_CLEAR_CMD)
                     ? word_data[seq_cmd_pkg::EVENT_HI:0] : '0;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (task_run_enable_r) state_nxt = ST_FETCH;
      end
      ST_FETCH: begin
        if (take) begin
          unique case (opc)
            seq_cmd_pkg::OP_STOP:       if (cond_stop) state_nxt = ST_IDLE;
            seq_cmd_pkg::OP_JUMP:       state_nxt = ST_OPERAND;
            seq_cmd_pkg::OP_PAUSE:      if (!cond_now) state_nxt = ST_WAIT;
            seq_cmd_pkg::OP_CHECK_LATE: if (!cond_now) state_nxt = ST_WAIT;
            default:                    state_nxt = ST_FETCH;
          endcase
        end
      end
      ST_OPERAND: begin
        if (take) state_nxt = ST_FETCH;
      end
      ST_WAIT: begin
        if (cond_held) state_nxt = ST_FETCH;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Ready is registered, so it looks at the coming state
  always_ff @(posedge clk) begin
    if (srst) begin
      word_ready_r <= 1'b0;
    end else begin
      word_ready_r <= (state_nxt == ST_FETCH) || (state_nxt == ST_OPERAND);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      held_r    <= '0;
      jump_go_r <= 1'b0;
    end else if (state_r == ST_FETCH && take) begin
      held_r    <= word_data;
      jump_go_r <= cond_stop;
    end
  end

  // ----------------------------------------------------------------
  // Run enable and program counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      task_run_enable_r <= 1'b0;
    end else if (state_r == ST_FETCH && take && opc == seq_cmd_pkg::OP_STOP && cond_stop) begin
      task_run_enable_r <= 1'b0;
    end else if (run_start) begin
      task_run_enable_r <= 1'b1;
    end
  end

  // Loading is refused while the task runs to keep the list coherent
  always_ff @(posedge clk) begin
    if (srst) begin
      task_program_counter_r <= seq_cmd_pkg::PC_RESET;
    end else if (state_r == ST_OPERAND && take && jump_go_r) begin
      task_program_counter_r <= word_data;
    end else if (take) begin
      task_program_counter_r <= task_program_counter_r + 32'(seq_cmd_pkg::ADDR_STEP);
    end else if (pc_load && state_r == ST_IDLE && !task_run_enable_r) begin
      task_program_counter_r <= pc_load_value;
    end
  end

  // ----------------------------------------------------------------
  // Flags, signals and upload
  // ----------------------------------------------------------------
  logic int_hit;
  logic late_hit;

  assign int_hit  = state_r == ST_FETCH && take && opc == seq_cmd_pkg::OP_INTERRUPT && cond_now;
  assign late_hit = state_r == ST_FETCH && take && opc == seq_cmd_pkg::OP_CHECK_LATE && cond_now;

  always_ff @(posedge clk) begin
    if (srst) begin
      task_interrupt_flag_r <= 1'b0;
    end else begin
      task_interrupt_flag_r <= int_hit || (task_interrupt_flag_r && !int_clear);
    end
  end

  // Condition already true when checked means the list fell behind
  always_ff @(posedge clk) begin
    if (srst) begin
      late_flag_r <= 1'b0;
    end else begin
      late_flag_r <= late_hit || (late_flag_r && !late_clear);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      upload_strobe_r   <= 1'b0;
      upload_sections_r <= '0;
    end else begin
      upload_strobe_r <= state_r == ST_FETCH && take && opc == seq_cmd_pkg::OP_UPLOAD;
      if (state_r == ST_FETCH && take && opc == seq_cmd_pkg::OP_UPLOAD) begin
        upload_sections_r <= word_data[seq_cmd_pkg::UPLOAD_HI:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      event_copy_r <= '0;
    end else begin
      event_copy_r <= events;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  stop_halts_a: assert property (@(posedge clk) disable iff (srst)
    (state_r == ST_FETCH && take && opc == seq_cmd_pkg::OP_STOP && cond_stop)
      |=> (!task_run_enable_r && state_r == ST_IDLE))
    else $error("stop did not halt the task");

  stop_skip_a: assert property (@(posedge clk) disable iff (srst)
    (state_r == ST_FETCH && take && opc == seq_cmd_pkg::OP_STOP && !cond_stop)
      |=> (state_r == ST_FETCH && task_run_enable_r))
    else $error("false stop halted the task");

  stop_empty_a: assert property (@(posedge clk) disable iff (srst)
    (state_r == ST_FETCH && take && opc == seq_cmd_pkg::OP_STOP
      && word_data[25:0] == 26'h0000000) |=> !task_run_enable_r)
    else $error("stop with no event did not halt");

  int_sets_a: assert property (@(posedge clk) disable iff (srst)
    (state_r == ST_FETCH && take && opc == seq_cmd_pkg::OP_INTERRUPT && cond_now)
      |=> (task_interrupt_flag_r && state_r == ST_FETCH))
    else $error("interrupt command did not set the flag");

  jump_load_a: assert property (@(posedge clk) disable iff (srst)
    (state_r == ST_OPERAND && take && jump_go_r)
      |=> task_program_counter_r == $past(word_data))
    else $error("taken jump did not load the counter");

  jump_skip_a: assert property (@(posedge clk) disable iff (srst)
    (state_r == ST_FETCH && take && opc == seq_cmd_pkg::OP_JUMP && !cond_stop)
      ##1 (state_r == ST_OPERAND && take)
      |=> task_program_counter_r == $past(task_program_counter_r, 2) + 32'h0000_0008)
    else $error("skipped jump did not advance past its operand");

  pause_holds_a: assert property (@(posedge clk) disable iff (srst)
    (state_r == ST_WAIT && !cond_held) |=> (state_r == ST_WAIT && !word_ready_r))
    else $error("pause left the wait state early");

  late_marks_a: assert property (@(posedge clk) disable iff (srst)
    (state_r == ST_FETCH && take && opc == seq_cmd_pkg::OP_CHECK_LATE && cond_now)
      |=> late_flag_r)
    else $error("late check did not raise late flag");

  upload_sect_a: assert property (@(posedge clk) disable iff (srst)
    (state_r == ST_FETCH && take && opc == seq_cmd_pkg::OP_UPLOAD)
      |=> (upload_strobe_r && upload_sections_r == $past(word_data[10:0])))
    else $error("upload sections not presented");

  signal_set_a: assert property (@(posedge clk) disable iff (srst)
    (sig_set != '0) |=> ((events & $past(sig_set)) == $past(sig_set)))
    else $error("set signal did not set event copies");

endmodule

// >>> seq_cmd_pkg.sv
// Shared constants of the sequencer command decoder: opcodes, field
// positions, widths and reset values. No clock or reset assumptions.
package seq_cmd_pkg;

  // ----------------------------------------------------------------
  // Command word layout
  // ----------------------------------------------------------------
  localparam int WORD_W      = 32;
  localparam int OPC_HI      = 31;
  localparam int OPC_LO      = 28;
  localparam int OPC_W       = 4;
  localparam int COMBINE_BIT = 27;
  localparam int INVERT_BIT  = 26;
  localparam int EVENT_HI    = 25;
  localparam int EVENT_W     = 26;
  localparam int UPLOAD_HI   = 10;
  localparam int UPLOAD_W    = 11;
  localparam int ADDR_STEP   = 4;

  // ----------------------------------------------------------------
  // Event bit positions inside the 26-bit event field
  // ----------------------------------------------------------------
  localparam int EV_TWO_WIRE_DONE   = 0;
  localparam int EV_EXP_BUS_DONE    = 1;
  localparam int EV_VDMA1_DONE      = 2;
  localparam int EV_VDMA3_DONE      = 4;
  localparam int EV_SCALER_WIN_IDLE = 5;
  localparam int EV_SCALER_LN_IDLE  = 6;
  localparam int EV_UNUSED          = 7;
  localparam int EV_VSCALER_IDLE    = 8;
  localparam int EV_BLANK_B         = 9;
  localparam int EV_BLANK_A         = 10;
  localparam int EV_EVEN_FIELD_A    = 11;
  localparam int EV_ODD_FIELD_A     = 12;
  localparam int EV_EVEN_FIELD_B    = 13;
  localparam int EV_ODD_FIELD_B     = 14;
  localparam int EV_SOURCE_LINE     = 15;
  localparam int EV_TARGET_LINE     = 16;
  localparam int EV_PIN_LO          = 17;
  localparam int EV_SIGNAL_LO       = 21;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_SIGNAL_CLEAR_CMD = 4'h0,
    OP_SET_SIGNAL = 4'h1,
    OP_PAUSE      = 4'h2,
    OP_CHECK_LATE = 4'h3,
    OP_UPLOAD     = 4'h4,
    OP_STOP       = 4'h5,
    OP_INTERRUPT  = 4'h6,
    OP_JUMP       = 4'h8
  } opcode_t;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [31:0] PC_RESET   = 32'h0000_0000;
  localparam logic [1:0]  SYNC_FILL  = 2'h3;

endpackage

// >>> event_copy_bank.sv
// Sequencer copies of the event sources: synchronised, edge driven,
// with command-driven set and clear. Sources are asynchronous to clk.
`timescale 1ns/1ps
module event_copy_bank #(
  parameter int N = 26
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Raw event sources
  input  wire logic [N-1:0] src_level,
  // Command-driven copies
  input  wire logic [N-1:0] set_mask,
  input  wire logic [N-1:0] clr_mask,
  // Event copies
  output logic      [N-1:0] events_r
);

  initial begin
    if (N < 1) $error("event_copy_bank: N must be positive");
  end

  // ----------------------------------------------------------------
  // Three-stage synchroniser; stage one feeds only stage two
  // ----------------------------------------------------------------
  logic [N-1:0] sync1_r;
  logic [N-1:0] sync2_r;
  logic [N-1:0] sync3_r;
  logic [N-1:0] stable_r;
  logic [1:0]   fill_r;
  logic [N-1:0] agree;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  logic         armed;

  always_ff @(posedge clk) begin
    sync1_r <= src_level;
    sync2_r <= sync1_r;
    sync3_r <= sync2_r;
  end

  assign armed = (fill_r == seq_cmd_pkg::SYNC_FILL);
  assign agree = ~(sync2_r ^ sync3_r);
  assign rise  = armed ? (agree & sync3_r & ~stable_r) : '0;
  assign fall  = armed ? (agree & ~sync3_r & stable_r) : '0;

  // Levels seen while the chain fills are taken silently
  always_ff @(posedge clk) begin
    if (srst) begin
      fill_r   <= 2'h0;
      stable_r <= '0;
    end else if (!armed) begin
      fill_r   <= fill_r + 2'h1;
      stable_r <= sync3_r;
    end else begin
      stable_r <= (stable_r & ~agree) | (sync3_r & agree);
    end
  end

  // Set beats clear when both land in one cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      events_r <= '0;
    end else begin
      events_r <= (events_r & ~(clr_mask | fall)) | set_mask | rise;
    end
  end

  rise_sets_a: assert property (@(posedge clk) disable iff (srst)
    (rise != '0) |=> ((events_r & $past(rise)) == $past(rise)))
    else $error("rising edge did not set its event copy");

endmodule

// >>> cmd_list_model.sv
// Command list in host memory, seen through the fetch DMA.
// Assumes the bench fills mem before the task is started.
`timescale 1ns/1ps
module cmd_list_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Fetch side
  input  wire logic        run_enable,
  input  wire logic [31:0] fetch_addr,
  input  wire logic        ready,
  output logic             valid,
  output logic [31:0]      data
);
  logic [31:0] mem [0:63];
  logic [31:0] last_addr_r;
  logic [31:0] last_data_r;
  logic        have_last_r;

  // One Dword per address; a word is offered once per counter value
  assign valid = run_enable && !(have_last_r && last_addr_r == fetch_addr);
  // Released data shows the inverse of the last word, never a stale copy
  assign data  = valid ? mem[fetch_addr[7:2]] : ~last_data_r;

  always_ff @(posedge clk) begin
    if (srst || !run_enable) begin
      have_last_r <= 1'b0;
    end else if (valid && ready) begin
      have_last_r <= 1'b1;
      last_addr_r <= fetch_addr;
    end
  end

  always_ff @(posedge clk) begin
    if (valid) begin
      last_data_r <= data;
    end
  end
endmodule

// >>> testbench.sv
// Self-checking bench for the sequencer command decoder.
// Assumes a single 50 MHz clock and a command list model on the fetch side.
`timescale 1ns/1ps
module testbench;
  logic        clk;
  logic        srst;
  logic        run_start;
  logic        pc_load;
  logic [31:0] pc_load_value;
  logic        int_clear;
  logic        late_clear;
  logic        word_valid;
  logic [31:0] word_data;
  logic        word_ready_r;
  logic [25:0] event_src;
  logic        task_run_enable_r;
  logic [31:0] task_program_counter_r;
  logic        task_interrupt_flag_r;
  logic        late_flag_r;
  logic [25:0] event_copy_r;
  logic        upload_strobe_r;
  logic [10:0] upload_sections_r;
  int          err_total;
  int          checked;
  int          up_cnt;

  sequencer_command_decoder #(.EVENT_W(26)) dut (
    .clk(clk), .srst(srst), .run_start(run_start), .pc_load(pc_load),
    .pc_load_value(pc_load_value), .int_clear(int_clear), .late_clear(late_clear),
    .word_valid(word_valid), .word_data(word_data), .word_ready_r(word_ready_r),
    .event_src(event_src), .task_run_enable_r(task_run_enable_r),
    .task_program_counter_r(task_program_counter_r),
    .task_interrupt_flag_r(task_interrupt_flag_r), .late_flag_r(late_flag_r),
    .event_copy_r(event_copy_r), .upload_strobe_r(upload_strobe_r),
    .upload_sections_r(upload_sections_r));

  cmd_list_model list (
    .clk(clk), .srst(srst), .run_enable(task_run_enable_r),
    .fetch_addr(task_program_counter_r), .ready(word_ready_r),
    .valid(word_valid), .data(word_data));

  always #10 clk = ~clk;

  always @(posedge clk) begin
    if (upload_strobe_r === 1'b1) begin
      up_cnt++;
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Load counter while idle, then start the task
  task automatic run_from(input logic [31:0] addr);
    pc_load = 1'b1;
    pc_load_value = addr;
    step(1);
    pc_load = 1'b0;
    run_start = 1'b1;
    step(1);
    run_start = 1'b0;
  endtask

  task automatic wait_stop;
    int i;
    for (i = 0; i < 400 && task_run_enable_r !== 1'b0; i++) begin
      step(1);
    end
    if (task_run_enable_r !== 1'b0) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, 1'b1, 1'b0);
      wrap_up();
    end
  endtask

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    run_start = 1'b0;
    pc_load = 1'b0;
    pc_load_value = 32'h0;
    int_clear = 1'b0;
    late_clear = 1'b0;
    event_src = 26'h0000001;
    err_total = 0;
    checked = 0;
    up_cnt = 0;
    // Program A: signals, conditional stops and jumps, upload
    list.mem[0] = 32'h1060_0000;
    list.mem[1] = 32'h0040_0000;
    list.mem[2] = 32'h5060_0000;
    list.mem[3] = 32'h5C20_0000;
    list.mem[4] = 32'h8860_0000;
    list.mem[5] = 32'h0000_0020;
    list.mem[6] = 32'h6000_0000;
    list.mem[7] = 32'h5000_0000;
    list.mem[8] = 32'h8420_0000;
    list.mem[9] = 32'h0000_0018;
    list.mem[10] = 32'h4000_0575;
    list.mem[11] = 32'h6060_0000;
    list.mem[12] = 32'h5400_0000;
    // Program B: interrupt, late check, plain jump, pause
    list.mem[16] = 32'h6020_0000;
    list.mem[17] = 32'h3020_0000;
    list.mem[18] = 32'h8800_0000;
    list.mem[19] = 32'h0000_0054;
    list.mem[20] = 32'h5000_0000;
    list.mem[21] = 32'h2000_0001;
    list.mem[22] = 32'h5000_0000;
    step(6);
    srst = 1'b0;
    step(10);
    check(event_copy_r, 26'h0);
    check(task_program_counter_r, 32'h0);
    check({task_run_enable_r, task_interrupt_flag_r, late_flag_r, word_ready_r}, 4'h0);
    event_src = 26'h0;
    step(8);
    $display("Test reset done");

    run_from(32'h0);
    wait_stop();
    check(task_program_counter_r, 32'h34);
    check(task_interrupt_flag_r, 1'b0);
    check(upload_sections_r, 11'h575);
    check(up_cnt, 1);
    step(2);
    check(event_copy_r[22:21], 2'b01);
    $display("Test program A done");

    run_from(32'h40);
    step(30);
    check(task_run_enable_r, 1'b1);
    check(word_ready_r, 1'b0);
    check(task_program_counter_r, 32'h58);
    check({task_interrupt_flag_r, late_flag_r}, 2'b11);
    pc_load = 1'b1;
    pc_load_value = 32'h100;
    step(1);
    pc_load = 1'b0;
    step(1);
    check(task_program_counter_r, 32'h58);
    event_src[0] = 1'b1;
    wait_stop();
    check(task_program_counter_r, 32'h5C);
    step(5);
    check(task_run_enable_r, 1'b0);
    check(event_copy_r[0], 1'b1);
    event_src[0] = 1'b0;
    step(8);
    check(event_copy_r[0], 1'b0);
    int_clear = 1'b1;
    late_clear = 1'b1;
    step(1);
    int_clear = 1'b0;
    late_clear = 1'b0;
    step(1);
    check({task_interrupt_flag_r, late_flag_r}, 2'b00);
    $display("Test program B done");
    wrap_up();
  end
endmodule
